// file: rdp_pkg.sv
// Constants shared by the radio data path blocks
// Behaviour
// - Sync demod estimates frequency from alternating preamble
// - Bit clock locks within four transitions
// - Sync demod suits index below two
// - Async demod suits OOK, high index, odd preamble
// - Async path deglitches data, offers sample clock
// - Async estimator works on any preamble
// - FIFO mode and direct mode exclusive
// - Host sends 77h, device shifts receive bytes
// - Packet handler wraps preamble, sync, CRC
// - Handler off: FIFO bytes sent untouched
// - Receive stores data bytes after sync
// - Live receive bits on a pin
// - Packet end returns to argument state
// - Direct transmit takes bits from chosen pin
// - GFSK direct drives transmit bit clock
// - Direct receive drives data, clock pins
// - Preamble valid after threshold bit count
// - Direct type bit: 0 sync, 1 async
package rdp_pkg;
	// Serial command codes
	localparam logic [7:0] CMD_WRITE_TX = 8'h66;
	localparam logic [7:0] CMD_READ_RX = 8'h77;
	// Modulation source field values
	localparam logic [1:0] SRC_FIFO = 2'h0;
	localparam logic [1:0] SRC_DIRECT = 2'h1;
	localparam logic [1:0] SRC_PRBS = 2'h2;
	// Modulation types
	localparam logic [2:0] MOD_OOK = 3'h1;
	localparam logic [2:0] MOD_2GFSK = 3'h3;
	localparam logic [2:0] MOD_4GFSK = 3'h5;
	localparam logic [3:0] MOD_INDEX_LIMIT = 4'h2;
	// Generated field contents
	localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [8:0] PRBS_SEED = 9'h1FF;
	// Transmit segment codes
	localparam logic [1:0] SEG_PRE = 2'h0;
	localparam logic [1:0] SEG_SYNC = 2'h1;
	localparam logic [1:0] SEG_DATA = 2'h2;
	localparam logic [1:0] SEG_CRC = 2'h3;
	// Reported state codes while busy and after reset
	localparam logic [3:0] CODE_IDLE = 4'h3;
	localparam logic [3:0] CODE_TX = 4'h7;
	localparam logic [3:0] CODE_RX = 4'h8;
	// Clock locking and averaging
	localparam logic [2:0] BCR_LOCK_TRANS = 3'h4;
	localparam logic [2:0] FE_LAST_SAMPLE = 3'h7;
	// Deglitch time and its cycle count at 25 ns
	localparam int DEGLITCH_NS = 100;
	localparam int CLK_PERIOD_NS = 25;
	localparam logic [7:0] DEGLITCH_CYCLES =
		8'((DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : rdp_pkg

// file: rdp_sync2.sv
// Two flip-flop synchroniser for pin and cross-domain levels
`timescale 1ns/1ps
module rdp_sync2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Levels in and out
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	// Both stages; only the second is read
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rdp_sync_t;

	rdp_sync_t q;
	rdp_sync_t next_q;

	// Shift chain
	always_comb begin
		next_q.s1 = i_d;
		next_q.s2 = q.s1;
	end

	// Register with synchronous clear
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_q = q.s2;
endmodule : rdp_sync2

// file: rdp_spi_link.sv
// Serial slave on the host clock: command decode and byte shifting
`timescale 1ns/1ps
module rdp_spi_link (
	// Link pins
	input wire logic i_sclk,
	input wire logic i_nsel,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe_n,
	// Clear from the system side
	input wire logic i_link_clear,
	// Byte exchange with the system side
	input wire logic [7:0] i_rd_byte,
	output logic [7:0] o_wr_byte,
	output logic o_wr_tog,
	output logic o_rd_tog
);
	// Per-frame state, cleared whenever select is high
	typedef struct packed {
		logic [2:0] bitcnt;
		logic [6:0] shreg;
		logic [7:0] cmd;
		logic have_cmd;
		logic [7:0] out_sr;
	} rdp_frame_t;

	// Event toggles survive frames; only system reset clears them
	typedef struct packed {
		logic wr_tog;
		logic rd_tog;
		logic [7:0] wr_byte;
	} rdp_event_t;

	rdp_frame_t f;
	rdp_frame_t next_f;
	rdp_event_t e;
	rdp_event_t next_e;
	logic [7:0] byte_in;

	// Bit and byte handling on each rising edge
	always_comb begin
		next_f = f;
		next_e = e;
		byte_in = {f.shreg, i_mosi};
		next_f.bitcnt = f.bitcnt + 3'h1;
		next_f.shreg = byte_in[6:0];
		next_f.out_sr = {f.out_sr[6:0], 1'b0};
		if (f.bitcnt == 3'h7) begin
			if (!f.have_cmd) begin
				// First byte is the command
				next_f.have_cmd = 1'b1;
				next_f.cmd = byte_in;
				if (byte_in == rdp_pkg::CMD_READ_RX) begin
					next_f.out_sr = i_rd_byte;
					next_e.rd_tog = ~e.rd_tog;
				end
			end else if (f.cmd == rdp_pkg::CMD_WRITE_TX) begin
				// Hand the byte over; it stays put for eight edges
				next_e.wr_byte = byte_in;
				next_e.wr_tog = ~e.wr_tog;
			end else if (f.cmd == rdp_pkg::CMD_READ_RX) begin
				next_f.out_sr = i_rd_byte;
				next_e.rd_tog = ~e.rd_tog;
			end
		end
	end

	// Frame part ends with the frame's own select
	always_ff @(posedge i_sclk or posedge i_nsel) begin
		if (i_nsel) begin
			f <= '0;
		end else begin
			f <= next_f;
		end
	end

	// Toggle part cleared only by the system reset level
	always_ff @(posedge i_sclk or posedge i_link_clear) begin
		if (i_link_clear) begin
			e <= '0;
		end else begin
			e <= next_e;
		end
	end

	// Output bit leaves a full clock early so the host samples it next rise
	assign o_miso = f.out_sr[7];
	assign o_miso_oe_n = i_nsel;
	assign o_wr_byte = e.wr_byte;
	assign o_wr_tog = e.wr_tog;
	assign o_rd_tog = e.rd_tog;
endmodule : rdp_spi_link

// file: rdp_data_path.sv
// Radio data path: FIFO transfer, packet framing, direct mode, demod support
`timescale 1ns/1ps
module rdp_data_path #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	// System clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	// Serial link from the host
	input wire logic I_SPI_SCLK,
	input wire logic I_SPI_NSEL,
	input wire logic I_SPI_MOSI,
	output logic O_SERIAL_DATA_OUTPUT,
	output logic O_SERIAL_DATA_OUTPUT_OE_N,
	// General purpose pins
	input wire logic [3:0] I_GPIO,
	output logic [3:0] O_GPIO,
	output logic [3:0] O_GPIO_OE_N,
	// Modulation setup
	input wire logic [2:0] I_MOD_TYPE,
	input wire logic [1:0] I_MODULATION_SOURCE_SELECT,
	input wire logic I_DIRECT_ASYNC,
	input wire logic [1:0] I_DIRECT_GPIO,
	input wire logic [1:0] I_DATA_OUT_GPIO,
	input wire logic [1:0] I_CLK_OUT_GPIO,
	input wire logic [3:0] I_MOD_INDEX,
	input wire logic I_STD_PREAMBLE,
	// Packet setup
	input wire logic I_PH_ENABLE,
	input wire logic [7:0] I_PREAMBLE_BYTES,
	input wire logic [7:0] I_PREAMBLE_THRESHOLD,
	input wire logic [23:0] I_SYNC_WORD,
	input wire logic I_SYNC_LEN3,
	input wire logic [7:0] I_PACKET_LEN,
	input wire logic [15:0] I_BIT_PERIOD,
	input wire logic I_DEMOD_ASYNC,
	// Start and abort commands with their return states
	input wire logic I_START_TX,
	input wire logic I_START_RX,
	input wire logic I_ABORT,
	input wire logic [3:0] I_AFTER_SEND_STATE,
	input wire logic [3:0] I_AFTER_RECEIVE_STATE,
	// Modem side
	input wire logic I_DEMOD_BIT,
	input wire logic [7:0] I_FREQ_SAMPLE,
	output logic O_TX_BIT,
	output logic O_TX_ACTIVE,
	// Status
	output logic [3:0] O_STATE,
	output logic O_EVENT_A,
	output logic O_PACKET_RECEIVED,
	output logic O_PREAMBLE_VALID,
	output logic O_SYNC_FOUND,
	output logic O_BCR_LOCKED,
	output logic [7:0] O_FREQ_ERR,
	output logic O_RECOMMEND_ASYNC
);
	typedef enum logic [1:0] {MODE_IDLE, MODE_TX, MODE_RX} rdp_mode_t;

	// Whole block state
	typedef struct packed {
		rdp_mode_t mode;
		logic [3:0] code;
		logic [3:0] after_arg;
		logic link_clear;
		logic [DEPTH-1:0][7:0] txm;
		logic [AW:0] tx_wp;
		logic [AW:0] tx_rp;
		logic [DEPTH-1:0][7:0] rxm;
		logic [AW:0] rx_wp;
		logic [AW:0] rx_rp;
		logic wr_seen;
		logic rd_seen;
		logic [7:0] rd_head;
		logic [15:0] tmr;
		logic [1:0] seg;
		logic [7:0] seg_cnt;
		logic [7:0] tx_shift;
		logic [2:0] tx_bidx;
		logic [7:0] crc;
		logic tx_bit;
		logic [8:0] prbs;
		logic [7:0] dg_cnt;
		logic dg_val;
		logic prev_bit;
		logic [2:0] trans_cnt;
		logic locked;
		logic [7:0] alt_run;
		logic pre_valid;
		logic last_bit;
		logic [23:0] sync_sr;
		logic sync_found;
		logic [7:0] rx_byte;
		logic [2:0] rx_bidx;
		logic [7:0] rx_count;
		logic [11:0] fe_acc;
		logic [2:0] fe_cnt;
		logic [7:0] freq_err;
		logic sent;
		logic recv;
		logic rec_async;
		logic [3:0] gpio;
		logic [3:0] gpio_oe_n;
	} rdp_state_t;

	rdp_state_t q;
	rdp_state_t next_q;

	// Crossing wires
	logic [7:0] wr_byte;
	logic wr_tog;
	logic rd_tog;
	logic [5:0] sync_in;
	logic [5:0] sync_out;
	logic [3:0] gpio_s;

	// Serial slave in the host clock domain
	rdp_spi_link u_link (
		.i_sclk(I_SPI_SCLK),
		.i_nsel(I_SPI_NSEL),
		.i_mosi(I_SPI_MOSI),
		.o_miso(O_SERIAL_DATA_OUTPUT),
		.o_miso_oe_n(O_SERIAL_DATA_OUTPUT_OE_N),
		.i_link_clear(q.link_clear),
		.i_rd_byte(q.rd_head),
		.o_wr_byte(wr_byte),
		.o_wr_tog(wr_tog),
		.o_rd_tog(rd_tog)
	);

	// Pins and toggles share one synchroniser bank
	assign sync_in = {rd_tog, wr_tog, I_GPIO};
	rdp_sync2 #(.W(6)) u_sync (
		.i_clk(I_SYS_CLK),
		.i_resetn(I_RESETN),
		.i_d(sync_in),
		.o_q(sync_out)
	);
	assign gpio_s = sync_out[3:0];

	// Bit timing and configuration decode
	logic tick;
	logic strobe;
	logic [15:0] half;
	logic fifo_mode;
	logic gfsk;
	logic sync_direct;
	assign half = I_BIT_PERIOD >> 1;
	assign tick = q.tmr == I_BIT_PERIOD - 16'h0001;
	assign strobe = q.tmr == half;
	assign fifo_mode = I_MODULATION_SOURCE_SELECT != rdp_pkg::SRC_DIRECT;
	assign gfsk = (I_MOD_TYPE == rdp_pkg::MOD_2GFSK) || (I_MOD_TYPE == rdp_pkg::MOD_4GFSK);
	// Asynchronous direct cannot carry GFSK, so GFSK forces the clocked form
	assign sync_direct = !I_DIRECT_ASYNC || gfsk;

	// Checksum over one byte, MSB first
	function automatic logic [7:0] rdp_crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ rdp_pkg::CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : rdp_crc8

	// Next-state logic
	always_comb begin
		logic [7:0] nb;
		logic have;
		logic [1:0] k;
		logic sel;
		logic rb;
		logic clk_on;
		logic data_on;
		logic clk_val;
		nb = 8'h00;
		have = 1'b0;
		k = 2'h0;
		sel = 1'b0;
		rb = 1'b0;
		clk_on = 1'b0;
		data_on = 1'b0;
		clk_val = 1'b0;
		next_q = q;
		next_q.link_clear = 1'b0;
		next_q.sent = 1'b0;
		next_q.recv = 1'b0;
		// Advice on demodulator choice from index, type and preamble
		next_q.rec_async = (I_MOD_TYPE == rdp_pkg::MOD_OOK)
			|| (I_MOD_INDEX >= rdp_pkg::MOD_INDEX_LIMIT)
			|| !I_STD_PREAMBLE;
		// Host writes into the transmit FIFO; ignored in direct mode
		next_q.wr_seen = sync_out[4];
		if ((sync_out[4] != q.wr_seen) && fifo_mode
			&& (q.tx_wp != {~q.tx_rp[AW], q.tx_rp[AW-1:0]})) begin
			next_q.txm[q.tx_wp[AW-1:0]] = wr_byte;
			next_q.tx_wp = q.tx_wp + 1'b1;
		end
		// Host took the head byte; pop it
		next_q.rd_seen = sync_out[5];
		if ((sync_out[5] != q.rd_seen) && (q.rx_wp != q.rx_rp)) begin
			next_q.rx_rp = q.rx_rp + 1'b1;
		end
		// Bit timer runs while busy
		next_q.tmr = (tick || q.mode == MODE_IDLE) ? 16'h0000 : q.tmr + 16'h0001;
		// Deglitch: level must hold several cycles before it counts
		if (I_DEMOD_BIT == q.dg_val) begin
			next_q.dg_cnt = 8'h00;
		end else if (q.dg_cnt == rdp_pkg::DEGLITCH_CYCLES - 8'h01) begin
			next_q.dg_cnt = 8'h00;
			next_q.dg_val = I_DEMOD_BIT;
		end else begin
			next_q.dg_cnt = q.dg_cnt + 8'h01;
		end
		sel = I_DEMOD_ASYNC ? q.dg_val : I_DEMOD_BIT;

		case (q.mode)
			MODE_TX: begin
				if (I_MODULATION_SOURCE_SELECT == rdp_pkg::SRC_DIRECT) begin
					// Real-time bits from the chosen pin
					if (!sync_direct) begin
						next_q.tx_bit = gpio_s[I_DIRECT_GPIO];
					end else if (tick) begin
						next_q.tx_bit = gpio_s[I_DIRECT_GPIO];
					end
				end else if (I_MODULATION_SOURCE_SELECT == rdp_pkg::SRC_PRBS) begin
					// Test pattern source
					if (tick) begin
						next_q.prbs = {q.prbs[7:0], q.prbs[8] ^ q.prbs[4]};
						next_q.tx_bit = q.prbs[8];
					end
				end else if (tick && q.tx_bidx != 3'h0) begin
					// Shift out the current byte
					next_q.tx_bit = q.tx_shift[7];
					next_q.tx_shift = {q.tx_shift[6:0], 1'b0};
					next_q.tx_bidx = q.tx_bidx - 3'h1;
				end else if (tick) begin
					// Fetch the next byte of the packet
					case (q.seg)
						rdp_pkg::SEG_PRE: begin
							nb = rdp_pkg::PREAMBLE_BYTE;
							have = 1'b1;
							next_q.seg_cnt = q.seg_cnt + 8'h01;
							if (q.seg_cnt + 8'h01 >= I_PREAMBLE_BYTES) begin
								next_q.seg = rdp_pkg::SEG_SYNC;
								next_q.seg_cnt = 8'h00;
							end
						end
						rdp_pkg::SEG_SYNC: begin
							k = q.seg_cnt[1:0] + (I_SYNC_LEN3 ? 2'h0 : 2'h1);
							case (k)
								2'h0: nb = I_SYNC_WORD[23:16];
								2'h1: nb = I_SYNC_WORD[15:8];
								default: nb = I_SYNC_WORD[7:0];
							endcase
							have = 1'b1;
							next_q.seg_cnt = q.seg_cnt + 8'h01;
							if (k == 2'h2) begin
								next_q.seg = rdp_pkg::SEG_DATA;
							end
						end
						rdp_pkg::SEG_DATA: begin
							if (q.tx_wp != q.tx_rp) begin
								nb = q.txm[q.tx_rp[AW-1:0]];
								have = 1'b1;
								next_q.tx_rp = q.tx_rp + 1'b1;
								next_q.crc = rdp_crc8(q.crc, nb);
							end else if (I_PH_ENABLE) begin
								nb = q.crc;
								have = 1'b1;
								next_q.seg = rdp_pkg::SEG_CRC;
							end
						end
						default: begin
							have = 1'b0;
						end
					endcase
					if (have) begin
						next_q.tx_bit = nb[7];
						next_q.tx_shift = {nb[6:0], 1'b0};
						next_q.tx_bidx = 3'h7;
					end else begin
						// Last bit gone: leave transmit on its own
						next_q.sent = 1'b1;
						next_q.mode = MODE_IDLE;
						next_q.code = q.after_arg;
					end
				end
			end
			MODE_RX: begin
				// Bit clock recovery realigns on every edge
				next_q.prev_bit = sel;
				if (sel != q.prev_bit) begin
					next_q.tmr = 16'h0000;
					if (q.trans_cnt != rdp_pkg::BCR_LOCK_TRANS) begin
						next_q.trans_cnt = q.trans_cnt + 3'h1;
					end
					if (q.trans_cnt + 3'h1 >= rdp_pkg::BCR_LOCK_TRANS) begin
						next_q.locked = 1'b1;
					end
				end
				if (strobe && (q.locked || I_DEMOD_ASYNC)) begin
					rb = sel;
					// Count alternating bits toward the threshold
					if (rb != q.last_bit && q.alt_run != 8'hFF) begin
						next_q.alt_run = q.alt_run + 8'h01;
					end else if (rb == q.last_bit) begin
						next_q.alt_run = 8'h01;
					end
					if (I_DEMOD_ASYNC || I_PREAMBLE_THRESHOLD == 8'h00
						|| next_q.alt_run >= I_PREAMBLE_THRESHOLD) begin
						next_q.pre_valid = 1'b1;
					end
					// Frequency error: sync path uses only alternating bits
					if (I_DEMOD_ASYNC || rb != q.last_bit) begin
						next_q.fe_acc = q.fe_acc + {{4{I_FREQ_SAMPLE[7]}}, I_FREQ_SAMPLE};
						next_q.fe_cnt = q.fe_cnt + 3'h1;
						if (q.fe_cnt == rdp_pkg::FE_LAST_SAMPLE) begin
							next_q.freq_err = next_q.fe_acc[10:3];
							next_q.fe_acc = 12'h000;
						end
					end
					next_q.last_bit = rb;
					next_q.sync_sr = {q.sync_sr[22:0], rb};
					if (!q.sync_found) begin
						// Look for the sync word only after a valid preamble
						if (q.pre_valid && (I_SYNC_LEN3 ? next_q.sync_sr == I_SYNC_WORD
							: next_q.sync_sr[15:0] == I_SYNC_WORD[15:0])) begin
							next_q.sync_found = 1'b1;
						end
					end else begin
						// Everything after sync is data
						next_q.rx_byte = {q.rx_byte[6:0], rb};
						next_q.rx_bidx = q.rx_bidx + 3'h1;
						if (q.rx_bidx == 3'h7) begin
							if (fifo_mode && (q.rx_wp != {~q.rx_rp[AW], q.rx_rp[AW-1:0]})) begin
								next_q.rxm[q.rx_wp[AW-1:0]] = {q.rx_byte[6:0], rb};
								next_q.rx_wp = q.rx_wp + 1'b1;
							end
							next_q.rx_count = q.rx_count + 8'h01;
							if (q.rx_count + 8'h01 == I_PACKET_LEN) begin
								next_q.recv = 1'b1;
								next_q.mode = MODE_IDLE;
								next_q.code = q.after_arg;
							end
						end
					end
				end
			end
			default: begin
				next_q.mode = MODE_IDLE;
			end
		endcase

		// Commands: start wins over a finishing packet
		if (I_ABORT) begin
			next_q.mode = MODE_IDLE;
			next_q.code = q.after_arg;
		end else if (I_START_TX) begin
			next_q.mode = MODE_TX;
			next_q.code = rdp_pkg::CODE_TX;
			next_q.after_arg = I_AFTER_SEND_STATE;
			next_q.seg = I_PH_ENABLE ? rdp_pkg::SEG_PRE : rdp_pkg::SEG_DATA;
			next_q.seg_cnt = 8'h00;
			next_q.tx_bidx = 3'h0;
			next_q.crc = 8'h00;
			next_q.tmr = I_BIT_PERIOD - 16'h0001;
		end else if (I_START_RX) begin
			next_q.mode = MODE_RX;
			next_q.code = rdp_pkg::CODE_RX;
			next_q.after_arg = I_AFTER_RECEIVE_STATE;
			next_q.trans_cnt = 3'h0;
			next_q.locked = 1'b0;
			next_q.alt_run = 8'h00;
			next_q.pre_valid = 1'b0;
			next_q.sync_found = 1'b0;
			next_q.rx_bidx = 3'h0;
			next_q.rx_count = 8'h00;
			next_q.fe_cnt = 3'h0;
			next_q.fe_acc = 12'h000;
		end

		// Head byte offered to the host, zero when empty
		next_q.rd_head = (next_q.rx_wp != next_q.rx_rp) ? next_q.rxm[next_q.rx_rp[AW-1:0]] : 8'h00;

		// Pin drive: data pin in receive, clock pin in direct receive or clocked direct send
		clk_val = q.tmr < half;
		for (int p = 0; p < 4; p++) begin
			data_on = (q.mode == MODE_RX) && (I_DATA_OUT_GPIO == p[1:0]);
			clk_on = (I_CLK_OUT_GPIO == p[1:0]) && (((q.mode == MODE_RX) && !fifo_mode)
				|| ((q.mode == MODE_TX) && !fifo_mode && sync_direct));
			next_q.gpio[p] = data_on ? sel : (clk_on ? clk_val : 1'b0);
			next_q.gpio_oe_n[p] = !(data_on || clk_on);
		end
	end

	// State register with synchronous reset
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RESETN) begin
			q <= '0;
			q.link_clear <= 1'b1;
			q.code <= rdp_pkg::CODE_IDLE;
			q.after_arg <= rdp_pkg::CODE_IDLE;
			q.prbs <= rdp_pkg::PRBS_SEED;
			q.gpio_oe_n <= 4'hF;
		end else begin
			q <= next_q;
		end
	end

	// Outputs
	assign O_GPIO = q.gpio;
	assign O_GPIO_OE_N = q.gpio_oe_n;
	assign O_TX_BIT = q.tx_bit;
	assign O_TX_ACTIVE = q.mode == MODE_TX;
	assign O_STATE = q.code;
	assign O_EVENT_A = q.sent;
	assign O_PACKET_RECEIVED = q.recv;
	assign O_PREAMBLE_VALID = q.pre_valid;
	assign O_SYNC_FOUND = q.sync_found;
	assign O_BCR_LOCKED = q.locked;
	assign O_FREQ_ERR = q.freq_err;
	assign O_RECOMMEND_ASYNC = q.rec_async;
endmodule : rdp_data_path

// file: rdp_host_model.sv
// Host microcontroller model on the serial link
`timescale 1ns/1ps
module rdp_host_model (
	// Link pins
	output logic o_sclk,
	output logic o_nsel,
	output logic o_mosi,
	input wire logic i_miso
);
	logic [7:0] rx_byte; // Last byte shifted in
	initial begin
		o_sclk = 1'b0;
		o_nsel = 1'b1;
		o_mosi = 1'b0;
		rx_byte = 8'h00;
	end
	// One byte MSB first, 30 ns clock only while selected
	task automatic shift(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			o_mosi = tx[i];
			#15;
			rx_byte = {rx_byte[6:0], i_miso};
			o_sclk = 1'b1;
			#15;
			o_sclk = 1'b0;
		end
	endtask : shift
	// Command then n bytes; read bytes gather into q
	task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] d,
		output logic [31:0] q);
		q = 32'h0;
		o_nsel = 1'b0;
		#20;
		shift(cmd);
		for (int k = 0; k < n; k++) begin
			shift(d[31-8*k -: 8]);
			q = {q[23:0], rx_byte};
		end
		#20;
		o_nsel = 1'b1;
		// Released data line must not keep its last value
		o_mosi = ~o_mosi;
		#100;
	endtask : frame
endmodule : rdp_host_model

// file: rdp_data_path_checker.sv
// Port checker for the radio data path
`timescale 1ns/1ps
module rdp_data_path_checker (
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RESETN,
	// Link select, read enable and pin enables
	input wire logic I_SPI_NSEL,
	input wire logic O_SERIAL_DATA_OUTPUT_OE_N,
	input wire logic [3:0] O_GPIO_OE_N,
	// Setup
	input wire logic [2:0] I_MOD_TYPE,
	input wire logic [3:0] I_MOD_INDEX,
	input wire logic I_STD_PREAMBLE,
	input wire logic [7:0] I_PREAMBLE_THRESHOLD,
	input wire logic I_DEMOD_ASYNC,
	// Commands
	input wire logic I_START_TX,
	input wire logic I_START_RX,
	input wire logic I_ABORT,
	input wire logic [3:0] I_AFTER_SEND_STATE,
	input wire logic [3:0] I_AFTER_RECEIVE_STATE,
	// Status
	input wire logic O_TX_ACTIVE,
	input wire logic [3:0] O_STATE,
	input wire logic O_EVENT_A,
	input wire logic O_PACKET_RECEIVED,
	input wire logic O_PREAMBLE_VALID,
	input wire logic O_SYNC_FOUND,
	input wire logic O_RECOMMEND_ASYNC
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RESETN);
	// Expected advice; the design registers it one cycle later
	logic rec_exp;
	assign rec_exp = (I_MOD_TYPE == rdp_pkg::MOD_OOK) || !I_STD_PREAMBLE ||
		(I_MOD_INDEX >= rdp_pkg::MOD_INDEX_LIMIT);
	// Reset must hold idle code and released pins
	a_reset_values: assert property (disable iff (1'b0) !I_RESETN |=>
		O_STATE == rdp_pkg::CODE_IDLE && O_GPIO_OE_N == 4'hF) else $error("reset values wrong");
	a_start_tx: assert property (I_START_TX && !I_ABORT |=>
		O_TX_ACTIVE && O_STATE == rdp_pkg::CODE_TX) else $error("transmit start missed");
	a_start_rx: assert property (I_START_RX && !I_START_TX && !I_ABORT |=>
		O_STATE == rdp_pkg::CODE_RX && !O_PREAMBLE_VALID && !O_SYNC_FOUND)
		else $error("receive start wrong");
	a_sent_return: assert property (O_EVENT_A |-> ##[0:1]
		(O_STATE == I_AFTER_SEND_STATE && !O_TX_ACTIVE)) else $error("no return after send");
	a_sent_single: assert property (O_EVENT_A |=> !O_EVENT_A)
		else $error("sent pulse too long");
	a_recv_return: assert property (O_PACKET_RECEIVED |-> ##[0:1]
		O_STATE == I_AFTER_RECEIVE_STATE) else $error("no return after receive");
	a_sync_needs_pre: assert property ($rose(O_SYNC_FOUND) && !I_DEMOD_ASYNC &&
		I_PREAMBLE_THRESHOLD != 8'h00 |-> O_PREAMBLE_VALID) else $error("sync before preamble");
	a_read_enable: assert property (O_SERIAL_DATA_OUTPUT_OE_N == I_SPI_NSEL)
		else $error("read data enable wrong");
	a_recommend_async: assert property (1'b1 |=> O_RECOMMEND_ASYNC == $past(rec_exp))
		else $error("demodulator advice wrong");
endmodule : rdp_data_path_checker

bind rdp_data_path rdp_data_path_checker u_rdp_data_path_checker (
	.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_SPI_NSEL(I_SPI_NSEL),
	.O_SERIAL_DATA_OUTPUT_OE_N(O_SERIAL_DATA_OUTPUT_OE_N), .O_GPIO_OE_N(O_GPIO_OE_N),
	.I_MOD_TYPE(I_MOD_TYPE), .I_MOD_INDEX(I_MOD_INDEX), .I_STD_PREAMBLE(I_STD_PREAMBLE),
	.I_PREAMBLE_THRESHOLD(I_PREAMBLE_THRESHOLD), .I_DEMOD_ASYNC(I_DEMOD_ASYNC),
	.I_START_TX(I_START_TX), .I_START_RX(I_START_RX), .I_ABORT(I_ABORT),
	.I_AFTER_SEND_STATE(I_AFTER_SEND_STATE), .I_AFTER_RECEIVE_STATE(I_AFTER_RECEIVE_STATE),
	.O_TX_ACTIVE(O_TX_ACTIVE), .O_STATE(O_STATE), .O_EVENT_A(O_EVENT_A),
	.O_PACKET_RECEIVED(O_PACKET_RECEIVED), .O_PREAMBLE_VALID(O_PREAMBLE_VALID),
	.O_SYNC_FOUND(O_SYNC_FOUND), .O_RECOMMEND_ASYNC(O_RECOMMEND_ASYNC)
);

// file: rdp_testbench.sv
// Self-checking bench for the radio data path
`timescale 1ns/1ps
module testbench;
	localparam int BP = 8; // Bit period in system cycles
	logic clk = 1'b0; // System clock
	logic rstn = 1'b0; // Reset, active low
	logic sclk, nsel, mosi, serial_data_output, sdo_oe_n; // Serial link
	wire miso_line = sdo_oe_n ? 1'b1 : serial_data_output; // Pulled up when released
	logic [3:0] gpio_in = 4'h0, gpio_out, gpio_oe_n, state, aft_s = 4'h5, aft_r = 4'h2;
	logic [2:0] mtype = 3'h2; // Modulation type
	logic [1:0] src = 2'h0; // Modulation source
	logic dasync = 1'b0, std = 1'b1, ph = 1'b0, dm_async = 1'b0, demod = 1'b0;
	logic start_tx = 1'b0, start_rx = 1'b0, abort = 1'b0;
	logic [3:0] midx = 4'h1; // Modulation index
	logic [7:0] thr = 8'h08, plen = 8'h02, pbytes = 8'h01, fsamp = 8'h10;
	logic [23:0] sw = 24'h002DD4; // Sync word, low two bytes used
	logic tx_bit, tx_act, ev_a, pkt_rx, pre_ok, sync_ok, locked, rec_async;
	logic [7:0] ferr; // Frequency error
	logic [31:0] q; // Read back bytes
	int fail_count = 0, compares = 0, ev_cnt = 0, rx_cnt = 0;
	// Rows: type, index, standard preamble, expected advice
	logic [8:0] rows [5] = '{9'h023, 9'h047, 9'h065, 9'h086, 9'h085};
	always #12.5 clk = ~clk;
	rdp_data_path u_rdp_data_path (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_SPI_SCLK(sclk),
		.I_SPI_NSEL(nsel), .I_SPI_MOSI(mosi), .O_SERIAL_DATA_OUTPUT(serial_data_output),
		.O_SERIAL_DATA_OUTPUT_OE_N(sdo_oe_n), .I_GPIO(gpio_in), .O_GPIO(gpio_out),
		.O_GPIO_OE_N(gpio_oe_n), .I_MOD_TYPE(mtype), .I_MODULATION_SOURCE_SELECT(src),
		.I_DIRECT_ASYNC(dasync), .I_DIRECT_GPIO(2'h2), .I_DATA_OUT_GPIO(2'h0),
		.I_CLK_OUT_GPIO(2'h3), .I_MOD_INDEX(midx), .I_STD_PREAMBLE(std), .I_PH_ENABLE(ph),
		.I_PREAMBLE_BYTES(pbytes), .I_PREAMBLE_THRESHOLD(thr), .I_SYNC_WORD(sw),
		.I_SYNC_LEN3(1'b0), .I_PACKET_LEN(plen), .I_BIT_PERIOD(16'h0008),
		.I_DEMOD_ASYNC(dm_async), .I_START_TX(start_tx), .I_START_RX(start_rx),
		.I_ABORT(abort), .I_AFTER_SEND_STATE(aft_s), .I_AFTER_RECEIVE_STATE(aft_r),
		.I_DEMOD_BIT(demod), .I_FREQ_SAMPLE(fsamp), .O_TX_BIT(tx_bit), .O_TX_ACTIVE(tx_act),
		.O_STATE(state), .O_EVENT_A(ev_a), .O_PACKET_RECEIVED(pkt_rx),
		.O_PREAMBLE_VALID(pre_ok), .O_SYNC_FOUND(sync_ok), .O_BCR_LOCKED(locked),
		.O_FREQ_ERR(ferr), .O_RECOMMEND_ASYNC(rec_async));
	rdp_host_model u_rdp_host_model (.o_sclk(sclk), .o_nsel(nsel), .o_mosi(mosi),
		.i_miso(miso_line));
	// Count end-of-packet pulses as they happen
	always @(posedge clk) begin
		if (ev_a === 1'b1) ev_cnt++;
		if (pkt_rx === 1'b1) rx_cnt++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask : pulse
	// Start a send and sample n bits 2.5 cycles into each bit, MSB first
	task automatic tx_check(input int n, input logic [39:0] exp);
		// Frames end off the clock grid; realign before the pulse
		@(negedge clk);
		pulse(start_tx);
		repeat (3) @(negedge clk);
		check(state, 32'h7);
		for (int i = 39; i > 39 - n; i--) begin
			check(tx_bit, exp[i]);
			repeat (BP) @(negedge clk);
		end
	endtask : tx_check
	// Feed demodulated bits; live pin checked late in each bit
	task automatic bits(input logic [31:0] v, input int n, input logic live);
		for (int i = n - 1; i >= 0; i--) begin
			demod = v[i];
			repeat (BP) @(negedge clk);
			if (live) check(gpio_out[0], v[i]);
		end
	endtask : bits
	task automatic conclude();
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	// Whole run is about 1400 cycles; this is far beyond it
	initial begin
		#400000;
		fail_count++;
		conclude();
	end
	initial begin
		// Two cycles of reset; the synchronisers clear with it
		repeat (2) @(negedge clk);
		check(state, 32'h3);
		check(gpio_oe_n, 32'hF);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		foreach (rows[i]) begin
			{mtype, midx, std} = rows[i][8:1];
			repeat (2) @(negedge clk);
			check(rec_async, rows[i][0]);
		end
		{mtype, midx, std} = 8'h43;
		// Raw frame, no generated fields
		u_rdp_host_model.frame(8'h66, 2, 32'hA53C0000, q);
		tx_check(16, 40'hA53C000000);
		repeat (2) @(negedge clk);
		check(ev_cnt, 32'h1);
		check(state, aft_s);
		// Handler adds preamble and sync before the data
		ph = 1'b1;
		u_rdp_host_model.frame(8'h66, 1, 32'h96000000, q);
		tx_check(40, 40'hAA2DD496EB);
		repeat (8 * BP + 2) @(negedge clk);
		check(ev_cnt, 32'h2);
		ph = 1'b0;
		// Receive with handler off
		pulse(start_rx);
		bits(32'h0000000A, 4, 1'b0);
		check(pre_ok, 32'h0);
		bits(32'h0AAAAAAA, 28, 1'b0);
		check(pre_ok, 32'h1);
		check(locked, 32'h1);
		check(sync_ok, 32'h0);
		bits(32'h2DD4C35A, 32, 1'b1);
		bits(32'h0, 8, 1'b0);
		check(rx_cnt, 32'h1);
		check(sync_ok, 32'h1);
		check(state, aft_r);
		check(ferr, 32'h10);
		u_rdp_host_model.frame(8'h77, 2, 32'h0, q);
		check(q[15:0], 32'hC35A);
		@(negedge clk);
		// Direct send: synchronous GFSK, then asynchronous 2FSK
		src = 2'h1;
		for (int k = 0; k < 2; k++) begin
			mtype = (k == 0) ? 3'h3 : 3'h2;
			dasync = (k == 1);
			pulse(start_tx);
			gpio_in[2] = 1'b1;
			repeat (3 * BP) @(negedge clk);
			check(tx_bit, 32'h1);
			if (k == 0) check(gpio_oe_n[3], 32'h0);
			gpio_in[2] = 1'b0;
			repeat (3 * BP) @(negedge clk);
			check(tx_bit, 32'h0);
			pulse(abort);
			@(negedge clk);
			check(tx_act, 32'h0);
		end
		// Async receive in direct mode: short glitches never reach the pin
		fsamp = 8'h20;
		dm_async = 1'b1;
		pulse(start_rx);
		demod = 1'b1;
		repeat (2) @(negedge clk);
		demod = 1'b0;
		repeat (BP) @(negedge clk);
		check(gpio_out[0], 32'h0);
		check(gpio_oe_n[3], 32'h0);
		bits(32'h3FF, 10, 1'b1);
		check(ferr, 32'h20);
		conclude();
	end
endmodule : testbench
